/* logic/lpc_pkg.sv */
// lpc_pkg: register map, field positions, reset values and key for the
// low power mode entry controller.
// assumes a 32-bit classic wishbone slave port and a 50 MHz system clock.
package lpc_pkg;
  // register byte offsets
  localparam logic [7:0] LPC_CORE0_CTRL_OFS = 8'h00;
  localparam logic [7:0] LPC_CORE1_CTRL_OFS = 8'h04;
  localparam logic [7:0] LPC_PWR_CTRL_OFS = 8'h08;
  localparam logic [7:0] LPC_HIB_CTRL_OFS = 8'h0c;
  localparam logic [7:0] LPC_HIB_DATA_OFS = 8'h10;
  localparam int LPC_ADDR_W = 8;

  // core sleep control fields
  localparam int LPC_AFTER_HANDLER_BIT = 1;
  localparam int LPC_DEEP_SEL_BIT = 2;
  localparam int LPC_WAKE_PEND_BIT = 4;

  // power control fields
  localparam int LPC_ULP_MODE_BIT = 0;
  localparam int LPC_READY_BIT = 5;
  localparam int LPC_SYS_STATE_LSB = 8;
  localparam int LPC_CORE_DEEP_LSB = 12;

  // hibernation control fields
  localparam int LPC_TAG_LSB = 0;
  localparam int LPC_TAG_W = 8;
  localparam int LPC_KEY_LSB = 8;
  localparam int LPC_KEY_W = 8;
  localparam int LPC_FREEZE_BIT = 17;
  localparam int LPC_ALARM_MASK_BIT = 18;
  localparam int LPC_POL_LSB = 20;
  localparam int LPC_PIN_MASK_LSB = 24;
  localparam int LPC_PINS = 4;
  localparam int LPC_HIB_REQ_BIT = 31;
  localparam logic [7:0] LPC_UNLOCK_KEY = 8'h3a;

  // reset values
  localparam logic [31:0] LPC_CORE_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LPC_HIB_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LPC_HIB_DATA_RST = 32'h0000_0000;

  // per-core sleep states
  typedef enum logic [1:0] {
    LPC_CORE_RUN,
    LPC_CORE_SLEEP,
    LPC_CORE_DEEP,
    LPC_CORE_HANDLER
  } lpc_core_state_t;

  // system power states
  typedef enum logic [1:0] {
    LPC_SYS_ACTIVE,
    LPC_SYS_DEEP,
    LPC_SYS_HIB
  } lpc_sys_state_t;
endpackage

/* logic/lpc_core.sv */
// lpc_core: sleep state of one cpu core and its clock gate.
// assumes wait, handler-done and interrupt inputs are on clk_i already.
`timescale 1ns/100ps
`default_nettype none
module lpc_core
  import lpc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sleep configuration
  input wire logic deep_sel_i,
  input wire logic after_handler_i,
  input wire logic wake_on_pend_i,
  // core events
  input wire logic wait_i,
  input wire logic handler_done_i,
  input wire logic irq_enabled_i,
  input wire logic irq_pending_i,
  input wire logic deep_irq_i,
  input wire logic sys_deep_i,
  // state out
  output logic clk_en_o,
  output logic deep_req_o
);
  lpc_core_state_t state_q, state_d;
  logic wake_any;
  logic wake_deep;

  // normal wake: enabled source, or any pending one when asked
  assign wake_any = irq_enabled_i | (wake_on_pend_i & irq_pending_i);
  // in system deep sleep only deep capable sources reach the core
  assign wake_deep = deep_irq_i | (!sys_deep_i & wake_any);

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      LPC_CORE_RUN: begin
        if (wait_i) begin
          state_d = deep_sel_i ? LPC_CORE_DEEP : LPC_CORE_SLEEP;
        end
      end
      LPC_CORE_SLEEP: begin
        if (wake_any) begin
          state_d = after_handler_i ? LPC_CORE_HANDLER : LPC_CORE_RUN;
        end
      end
      LPC_CORE_DEEP: begin
        if (wake_deep) begin
          state_d = after_handler_i ? LPC_CORE_HANDLER : LPC_CORE_RUN;
        end
      end
      LPC_CORE_HANDLER: begin
        // back to sleep once serviced, never to application code
        if (handler_done_i) begin
          state_d = deep_sel_i ? LPC_CORE_DEEP : LPC_CORE_SLEEP;
        end
      end
      default: state_d = LPC_CORE_RUN;
    endcase
  end

  // state register; outputs follow the state for glitch-free gating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= LPC_CORE_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign clk_en_o = (state_q == LPC_CORE_RUN) || (state_q == LPC_CORE_HANDLER);
  assign deep_req_o = (state_q == LPC_CORE_DEEP);
endmodule
`default_nettype wire

/* logic/lpc_ctrl.sv */
// lpc_ctrl: low power mode entry controller for a two-core device.
// assumes a classic wishbone master on clk_i, core events on clk_i and
// wake pins / alarm arriving asynchronously.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module lpc_ctrl
  import lpc_pkg::*;
#(
  parameter int NUM_CORES = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [LPC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core events, one bit per core
  input wire logic [NUM_CORES-1:0] wait_i,
  input wire logic [NUM_CORES-1:0] handler_done_i,
  input wire logic [NUM_CORES-1:0] irq_enabled_i,
  input wire logic [NUM_CORES-1:0] irq_pending_i,
  input wire logic [NUM_CORES-1:0] deep_irq_i,
  // power status and wake sources
  input wire logic ready_i,
  input wire logic [LPC_PINS-1:0] wake_pin_i,
  input wire logic wake_alarm_i,
  // power and clock controls
  output logic [NUM_CORES-1:0] core_clk_en_o,
  output logic hf_clk_en_o,
  output logic lf_clk_en_o,
  output logic retention_o,
  output logic nonret_rst_o,
  output logic active_reg_en_o,
  output logic deep_reg_en_o,
  output logic ulp_mode_o,
  output logic io_freeze_o,
  output logic device_rst_o
);
  // the system fsm is written for exactly two cores
  if (NUM_CORES != 2) begin : g_bad_cores
    $error("lpc_ctrl supports exactly two cores");
  end

  // merge a write into a word under byte enables, used for every register but the power control
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---- register state ----
  logic [31:0] core_ctrl_q [NUM_CORES];
  logic [31:0] core_ctrl_d [NUM_CORES];
  logic ulp_q, ulp_d;
  logic [31:0] hib_q, hib_d;
  logic [31:0] hib_data_q, hib_data_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic access;
  logic wr;

  // ---- system state ----
  lpc_sys_state_t sys_q, sys_d;
  logic [NUM_CORES-1:0] deep_req;
  logic [NUM_CORES-1:0] core_clk_en;
  logic [LPC_PINS-1:0] pin_s1_q, pin_s2_q;
  logic alarm_s1_q, alarm_s2_q;
  logic hib_wake;
  logic wake_from_hib;
  logic any_deep_irq;
  logic [NUM_CORES-1:0] clk_en_q;
  logic hf_q, lf_q, ret_q, nrr_q, areg_q, dreg_q, drst_q;
  logic hf_d, lf_d, ret_d, nrr_d, areg_d, dreg_d, drst_d;

  // one access per request; ack drops in the cycle after it was given
  assign access = wb_cyc_i & wb_stb_i & !ack_q;
  assign wr = access & wb_we_i;

  // per-core sleep machines
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    lpc_core u_core (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .deep_sel_i(core_ctrl_q[c][LPC_DEEP_SEL_BIT]),
      .after_handler_i(core_ctrl_q[c][LPC_AFTER_HANDLER_BIT]),
      .wake_on_pend_i(core_ctrl_q[c][LPC_WAKE_PEND_BIT]),
      .wait_i(wait_i[c]),
      .handler_done_i(handler_done_i[c]),
      .irq_enabled_i(irq_enabled_i[c]),
      .irq_pending_i(irq_pending_i[c]),
      .deep_irq_i(deep_irq_i[c]),
      .sys_deep_i(sys_q == LPC_SYS_DEEP),
      .clk_en_o(core_clk_en[c]),
      .deep_req_o(deep_req[c])
    );
  end

  // register writes and read mux
  always_comb begin
    logic [31:0] hib_w;
    logic [7:0] key_eff;
    hib_w = wb_merge(hib_q, wb_dat_i, wb_sel_i);
    key_eff = hib_w[LPC_KEY_LSB +: LPC_KEY_W];
    for (int c = 0; c < NUM_CORES; c++) begin
      core_ctrl_d[c] = core_ctrl_q[c];
    end
    ulp_d = ulp_q;
    hib_d = hib_q;
    hib_data_d = hib_data_q;
    rdata_d = rdata_q;
    ack_d = access;
    if (wr) begin
      case (wb_adr_i)
        LPC_CORE0_CTRL_OFS: core_ctrl_d[0] = wb_merge(core_ctrl_q[0], wb_dat_i, wb_sel_i);
        LPC_CORE1_CTRL_OFS: core_ctrl_d[1] = wb_merge(core_ctrl_q[1], wb_dat_i, wb_sel_i);
        LPC_PWR_CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            ulp_d = wb_dat_i[LPC_ULP_MODE_BIT];
          end
        end
        LPC_HIB_CTRL_OFS: begin
          hib_d = hib_w;
          // guarded bits move only under the unlock key
          if (key_eff != LPC_UNLOCK_KEY) begin
            hib_d[LPC_FREEZE_BIT] = hib_q[LPC_FREEZE_BIT];
            hib_d[LPC_HIB_REQ_BIT] = hib_q[LPC_HIB_REQ_BIT];
          end
        end
        LPC_HIB_DATA_OFS: hib_data_d = wb_merge(hib_data_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    // a wake consumes the hibernate request; freeze is left set
    if (wake_from_hib) begin
      hib_d[LPC_HIB_REQ_BIT] = 1'b0;
    end
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        LPC_CORE0_CTRL_OFS: rdata_d = core_ctrl_q[0];
        LPC_CORE1_CTRL_OFS: rdata_d = core_ctrl_q[1];
        LPC_PWR_CTRL_OFS: begin
          rdata_d = 32'h0000_0000;
          rdata_d[LPC_ULP_MODE_BIT] = ulp_q;
          rdata_d[LPC_READY_BIT] = ready_i;
          rdata_d[LPC_SYS_STATE_LSB +: 2] = sys_q;
          rdata_d[LPC_CORE_DEEP_LSB +: NUM_CORES] = deep_req;
        end
        LPC_HIB_CTRL_OFS: rdata_d = hib_q;
        LPC_HIB_DATA_OFS: rdata_d = hib_data_q;
        default: rdata_d = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CORES; c++) begin
        core_ctrl_q[c] <= LPC_CORE_CTRL_RST;
      end
      ulp_q <= 1'b0;
      hib_q <= LPC_HIB_CTRL_RST;
      hib_data_q <= LPC_HIB_DATA_RST;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_CORES; c++) begin
        core_ctrl_q[c] <= core_ctrl_d[c];
      end
      ulp_q <= ulp_d;
      hib_q <= hib_d;
      hib_data_q <= hib_data_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // wake pins and alarm cross in through two flops each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      alarm_s1_q <= 1'b0;
      alarm_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= wake_pin_i;
      pin_s2_q <= pin_s1_q;
      alarm_s1_q <= wake_alarm_i;
      alarm_s2_q <= alarm_s1_q;
    end
  end

  // polarity flips a pin to active level, mask bit set enables it
  assign hib_wake = |((pin_s2_q ~^ hib_q[LPC_POL_LSB +: LPC_PINS])
                      & hib_q[LPC_PIN_MASK_LSB +: LPC_PINS])
                    | (alarm_s2_q & hib_q[LPC_ALARM_MASK_BIT]);
  assign wake_from_hib = (sys_q == LPC_SYS_HIB) && hib_wake;
  assign any_deep_irq = |deep_irq_i;

  // system power state and its controls
  always_comb begin
    sys_d = sys_q;
    case (sys_q)
      LPC_SYS_ACTIVE: begin
        if (hib_q[LPC_HIB_REQ_BIT]) begin
          sys_d = LPC_SYS_HIB;
        end else if ((&deep_req) && ready_i) begin
          sys_d = LPC_SYS_DEEP;
        end
      end
      LPC_SYS_DEEP: begin
        if (any_deep_irq) begin
          sys_d = LPC_SYS_ACTIVE;
        end
      end
      LPC_SYS_HIB: begin
        if (hib_wake) begin
          sys_d = LPC_SYS_ACTIVE;
        end
      end
      default: sys_d = LPC_SYS_ACTIVE;
    endcase
    // controls follow the next state so they change with the state flop
    hf_d = (sys_d == LPC_SYS_ACTIVE);
    lf_d = (sys_d != LPC_SYS_HIB);
    ret_d = (sys_d != LPC_SYS_ACTIVE);
    nrr_d = (sys_d != LPC_SYS_ACTIVE);
    areg_d = (sys_d == LPC_SYS_ACTIVE);
    dreg_d = (sys_d == LPC_SYS_DEEP);
    drst_d = wake_from_hib;
  end

  // system flops; the core clock enables and the clock, regulator, retention and reset outputs come from here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_q <= LPC_SYS_ACTIVE;
      clk_en_q <= '1;
      hf_q <= 1'b1;
      lf_q <= 1'b1;
      ret_q <= 1'b0;
      nrr_q <= 1'b0;
      areg_q <= 1'b1;
      dreg_q <= 1'b0;
      drst_q <= 1'b0;
    end else begin
      sys_q <= sys_d;
      clk_en_q <= core_clk_en;
      hf_q <= hf_d;
      lf_q <= lf_d;
      ret_q <= ret_d;
      nrr_q <= nrr_d;
      areg_q <= areg_d;
      dreg_q <= dreg_d;
      drst_q <= drst_d;
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign core_clk_en_o = clk_en_q;
  assign hf_clk_en_o = hf_q;
  assign lf_clk_en_o = lf_q;
  assign retention_o = ret_q;
  assign nonret_rst_o = nrr_q;
  assign active_reg_en_o = areg_q;
  assign deep_reg_en_o = dreg_q;
  assign ulp_mode_o = ulp_q; // previous mode is kept across deep sleep
  assign io_freeze_o = hib_q[LPC_FREEZE_BIT];

  // ---- checks ----
  shallow_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (g_core[0].u_core.state_q == LPC_CORE_RUN) && wait_i[0]
      && !core_ctrl_q[0][LPC_DEEP_SEL_BIT] |=> ##1 !core_clk_en_o[0])
    else $error("core 0 clock not gated after shallow wait");
  handler_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (g_core[0].u_core.state_q == LPC_CORE_HANDLER) && handler_done_i[0]
      |=> g_core[0].u_core.state_q != LPC_CORE_RUN)
    else $error("core resumed application after handler");
  pend_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (g_core[0].u_core.state_q == LPC_CORE_SLEEP) && irq_pending_i[0]
      && core_ctrl_q[0][LPC_WAKE_PEND_BIT] |=> ##1 core_clk_en_o[0])
    else $error("pending interrupt did not wake core");
  one_deep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sys_q == LPC_SYS_ACTIVE) && (deep_req != 2'b11) && !hib_q[LPC_HIB_REQ_BIT]
      |=> sys_q == LPC_SYS_ACTIVE)
    else $error("system left active with one core awake");
  deep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sys_q == LPC_SYS_ACTIVE) && (&deep_req) && ready_i && !hib_q[LPC_HIB_REQ_BIT]
      |=> sys_q == LPC_SYS_DEEP)
    else $error("no system deep sleep entry");
  deep_ctrls_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sys_q == LPC_SYS_DEEP |-> !hf_clk_en_o && retention_o && nonret_rst_o
      && !active_reg_en_o && deep_reg_en_o)
    else $error("deep sleep controls wrong");
  deep_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sys_q == LPC_SYS_DEEP) && any_deep_irq |=> hf_clk_en_o && active_reg_en_o
      && !retention_o && !nonret_rst_o && $stable(ulp_mode_o))
    else $error("deep sleep exit controls wrong");
  key_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && (wb_adr_i == LPC_HIB_CTRL_OFS)
      && ((wb_sel_i[1] ? wb_dat_i[LPC_KEY_LSB +: LPC_KEY_W]
        : hib_q[LPC_KEY_LSB +: LPC_KEY_W]) != LPC_UNLOCK_KEY) |=> $stable(io_freeze_o))
    else $error("freeze changed without key");
  hib_clocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sys_q == LPC_SYS_HIB |-> !lf_clk_en_o && !hf_clk_en_o)
    else $error("clocks running in hibernate");
  hib_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_from_hib |=> device_rst_o && io_freeze_o == $past(io_freeze_o)
      ##1 !device_rst_o)
    else $error("hibernate wake reset wrong");
  deep_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (g_core[0].u_core.state_q == LPC_CORE_RUN) && wait_i[0]
      && core_ctrl_q[0][LPC_DEEP_SEL_BIT] |=> deep_req[0])
    else $error("deep core makes no request");
  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack timing wrong");

  sys_deep_c: cover property (@(posedge clk_i) disable iff (rst_i)
    sys_q == LPC_SYS_ACTIVE ##1 sys_q == LPC_SYS_DEEP);
  hib_round_c: cover property (@(posedge clk_i) disable iff (rst_i)
    sys_q == LPC_SYS_HIB ##1 device_rst_o);
  handler_c: cover property (@(posedge clk_i) disable iff (rst_i)
    g_core[1].u_core.state_q == LPC_CORE_HANDLER ##1
      g_core[1].u_core.state_q == LPC_CORE_SLEEP);
  deep_exit_c: cover property (@(posedge clk_i) disable iff (rst_i)
    sys_q == LPC_SYS_DEEP ##1 sys_q == LPC_SYS_ACTIVE);

  assign device_rst_o = drst_q;
endmodule
`default_nettype wire

/* tb/lpc_cpu_model.sv */
// lpc_cpu_model: behavioural stand-in for the two cpu cores at the far side.
// assumes clk_i is the system clock and the bench commands each wait.
`timescale 1ns/100ps
`default_nettype none
module lpc_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench commands
  input wire logic [1:0] wait_cmd_i,
  input wire logic [1:0] svc_en_i,
  input wire logic [3:0] svc_cycles_i,
  // clock gate seen by each core
  input wire logic [1:0] core_clk_en_i,
  // core events
  output logic [1:0] wait_o,
  output logic [1:0] handler_done_o
);
  logic [3:0] run_cnt_q [2];

  // a gated core cannot execute anything, so wait only leaves a running core
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      wait_o[c] <= wait_cmd_i[c] & core_clk_en_i[c] & ~rst_i;
      handler_done_o[c] <= 1'b0;
      // svc_cycles_i sets how slowly the handler finishes
      if (rst_i || !core_clk_en_i[c] || !svc_en_i[c]) begin
        run_cnt_q[c] <= 4'h0;
      end else if (run_cnt_q[c] == svc_cycles_i) begin
        handler_done_o[c] <= 1'b1;
        run_cnt_q[c] <= 4'h0;
      end else begin
        run_cnt_q[c] <= run_cnt_q[c] + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// tb_top: self-checking bench for the low power mode entry controller.
// assumes lpc_pkg offsets and a one-wait-state classic wishbone slave.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import lpc_pkg::*;
;
  typedef struct packed {
    logic [31:0] wdat;
    logic frz;
    logic [31:0] exp;
  } lpc_tb_row_t;

  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, svc_cycles, wake_pin;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [1:0] wait_cmd, svc_en, wait_w, done_w, irq_en, irq_pend, deep_irq, core_clk;
  logic ready, alarm, hf, lf, ret, nonret, act_reg, deep_reg, ultra_low_power_state, freeze, dev_rst;
  int n_fail, num_checks;
  // freeze and hibernate only move when the same write carries the key
  localparam lpc_tb_row_t ROWS [6] = '{
    '{32'h0ab4_3aa5, 1'b0, 32'h0ab4_00a5}, '{32'h0006_3a11, 1'b1, 32'h0006_0011},
    '{32'h0000_0022, 1'b1, 32'h0002_0022}, '{32'h0050_3b33, 1'b1, 32'h0052_0033},
    '{32'h0f00_3a44, 1'b0, 32'h0f00_0044}, '{32'h8002_c566, 1'b0, 32'h0000_0066}};

  lpc_ctrl #(.NUM_CORES(2)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .wait_i(wait_w), .handler_done_i(done_w), .irq_enabled_i(irq_en),
    .irq_pending_i(irq_pend), .deep_irq_i(deep_irq), .ready_i(ready), .wake_pin_i(wake_pin),
    .wake_alarm_i(alarm), .core_clk_en_o(core_clk), .hf_clk_en_o(hf), .lf_clk_en_o(lf),
    .retention_o(ret), .nonret_rst_o(nonret), .active_reg_en_o(act_reg),
    .deep_reg_en_o(deep_reg), .ulp_mode_o(ultra_low_power_state), .io_freeze_o(freeze), .device_rst_o(dev_rst));

  lpc_cpu_model cpus (
    .clk_i(clk_i), .rst_i(rst_i), .wait_cmd_i(wait_cmd), .svc_en_i(svc_en),
    .svc_cycles_i(svc_cycles), .core_clk_en_i(core_clk), .wait_o(wait_w),
    .handler_done_o(done_w));

  // free-running 50 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle: hold everything until ack is sampled, then release
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    chk(n, 2); // ack one wait state after the taking edge
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    wb_xfer(1'b0, a, 32'h0);
  endtask

  // the wait is a single pulse, issued by the core model
  task automatic core_wait(input int c);
    @(posedge clk_i);
    wait_cmd[c] <= 1'b1;
    @(posedge clk_i);
    wait_cmd[c] <= 1'b0;
    tick(4);
  endtask

  task automatic chk_rst;
    chk({hf, lf, act_reg, ret, nonret, deep_reg, freeze, dev_rst, core_clk}, 10'h383);
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end

  // main sequence
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
    {wait_cmd, svc_en, irq_en, irq_pend, deep_irq, wake_pin, ready, alarm} = '0;
    svc_cycles = 4'h5;
    n_fail = 0;
    num_checks = 0;
    rst_i = 1'b1;
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    chk_rst();
    rdr(LPC_HIB_CTRL_OFS);
    chk(rd, LPC_HIB_CTRL_RST);
    rdr(LPC_CORE0_CTRL_OFS);
    chk(rd, LPC_CORE_CTRL_RST);
    for (int i = 0; i < 6; i++) begin
      wr(LPC_HIB_CTRL_OFS, ROWS[i].wdat);
      rdr(LPC_HIB_CTRL_OFS);
      chk(rd & 32'h8ff6_00ff, ROWS[i].exp);
      chk(freeze, ROWS[i].frz);
    end
    wr(LPC_HIB_DATA_OFS, 32'h5a5a_c3c3);
    rdr(LPC_HIB_DATA_OFS);
    chk(rd, 32'h5a5a_c3c3);
    wr(8'h3c, 32'hffff_ffff);
    rdr(8'h3c);
    chk(rd, 32'h0);
    // shallow sleep: pending alone must not wake until bit 4 is set
    wr(LPC_CORE0_CTRL_OFS, 32'h0);
    rdr(LPC_CORE0_CTRL_OFS);
    core_wait(0);
    chk({hf, core_clk}, 3'b110);
    irq_pend <= 2'b01;
    tick(4);
    chk(core_clk, 2'b10);
    irq_pend <= 2'b00;
    irq_en <= 2'b01;
    tick(4);
    chk(core_clk, 2'b11);
    irq_en <= 2'b00;
    wr(LPC_CORE0_CTRL_OFS, 32'h10);
    rdr(LPC_CORE0_CTRL_OFS);
    chk(rd & 32'h16, 32'h10);
    core_wait(0);
    irq_pend <= 2'b01;
    tick(4);
    chk(core_clk, 2'b11);
    irq_pend <= 2'b00;
    // sleep after handler: back to sleep once the model finishes servicing
    wr(LPC_CORE0_CTRL_OFS, 32'h2);
    rdr(LPC_CORE0_CTRL_OFS);
    svc_en <= 2'b01;
    core_wait(0);
    irq_en <= 2'b01;
    tick(1);
    irq_en <= 2'b00;
    tick(3);
    chk(core_clk, 2'b11);
    tick(10);
    chk(core_clk, 2'b10);
    svc_en <= 2'b00;
    wr(LPC_CORE0_CTRL_OFS, 32'h0);
    irq_en <= 2'b01;
    tick(4);
    irq_en <= 2'b00;
    chk(core_clk, 2'b11);
    // deep sleep: one core alone, then both but not ready, then ready
    wr(LPC_PWR_CTRL_OFS, 32'h1);
    wr(LPC_CORE0_CTRL_OFS, 32'h4);
    wr(LPC_CORE1_CTRL_OFS, 32'h4);
    rdr(LPC_CORE1_CTRL_OFS);
    core_wait(0);
    rdr(LPC_PWR_CTRL_OFS);
    chk(rd & 32'h3321, 32'h1001);
    chk({core_clk, hf}, 3'b101);
    // an enabled non-deep interrupt still wakes a lone deep core
    irq_en <= 2'b01;
    tick(4);
    irq_en <= 2'b00;
    chk(core_clk, 2'b11);
    core_wait(0);
    core_wait(1);
    chk({hf, ret}, 2'b10);
    ready <= 1'b1;
    rdr(LPC_PWR_CTRL_OFS);
    chk(rd & 32'h3321, 32'h3121);
    chk({hf, lf, ret, nonret, act_reg, deep_reg, core_clk}, 8'h74);
    deep_irq <= 2'b01;
    tick(4);
    deep_irq <= 2'b00;
    chk({hf, ret, nonret, act_reg, deep_reg, ultra_low_power_state, core_clk}, 8'h95);
    deep_irq <= 2'b10;
    tick(4);
    deep_irq <= 2'b00;
    chk(core_clk, 2'b11);
    // hibernate with freeze, woken by pin 0 active high
    rdr(LPC_PWR_CTRL_OFS);
    chk(rd[5], 1'b1);
    wr(LPC_HIB_CTRL_OFS, 32'h0112_3a00);
    wr(LPC_HIB_CTRL_OFS, 32'h8112_3a00);
    rdr(LPC_HIB_CTRL_OFS);
    tick(2);
    chk({hf, lf, ret, freeze}, 4'b0011);
    wake_pin <= 4'h1;
    for (int k = 0; k < 20 && dev_rst !== 1'b1; k++) @(posedge clk_i);
    chk(dev_rst, 1'b1);
    wake_pin <= 4'h0;
    tick(4);
    chk({hf, lf, freeze}, 3'b111);
    rdr(LPC_HIB_CTRL_OFS);
    chk(rd[31], 1'b0);
    wr(LPC_HIB_CTRL_OFS, 32'h0000_3a00);
    tick(2);
    chk(freeze, 1'b0);
    // hibernate again, woken by the alarm alone
    wr(LPC_HIB_CTRL_OFS, 32'h0004_3a00);
    wr(LPC_HIB_CTRL_OFS, 32'h8004_3a00);
    rdr(LPC_HIB_CTRL_OFS);
    tick(2);
    chk({lf, dev_rst}, 2'b00);
    alarm <= 1'b1;
    for (int k = 0; k < 20 && dev_rst !== 1'b1; k++) @(posedge clk_i);
    chk(dev_rst, 1'b1);
    alarm <= 1'b0;
    tick(2);
    // second reset in mid-run
    rst_i <= 1'b1;
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    chk_rst();
    end_sim();
  end
endmodule
`default_nettype wire
